// file: src/msc_standby_ctrl.sv
// Standby control register two: module clock stops and mode pin relatch
// Function
// - Provide an 8-bit read/write standby control register two configuring power-down.
// - Bits 7 and 0 read as zero; software writes zero there.
// - Bit 6 set: re-latch six mode pins on standby exit by reset/interrupt.
// - Bit 5 set stops the user break controller clock; clear runs it.
// - Bit 4 set stops the DMA controller clock; clear runs it.
// - Bit 3 set stops the DAC clock; clear runs it.
// - Bit 2 set stops the ADC clock and holds its registers in init.
// - Bit 1 set stops the FIFO serial interface clock; clear runs it.
//
// Local design decisions: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
module msc_standby_ctrl (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [msc_pkg::ADDR_W-1:0] addr_i,
    input wire logic [msc_pkg::DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [msc_pkg::DATA_W-1:0] rdata_o,
    input wire logic standby_active_i,
    input wire logic standby_exit_i,
    input wire logic [msc_pkg::MODE_W-1:0] mode_select_pins_i,
    output logic [msc_pkg::MODE_W-1:0] mode_latched_o,
    output logic user_break_controller_clk_en_o,
    output logic dma_clk_en_o,
    output logic dac_clk_en_o,
    output logic adc_clk_en_o,
    output logic fifo_serial_interface_clk_en_o,
    output logic adc_init_o
);
    import msc_pkg::*;

    logic [DATA_W-1:0] ctrl_reg;
    logic [DATA_W-1:0] ctrl_next;
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rdata_next;
    logic [MODE_W-1:0] mode_reg;
    logic [MODE_W-1:0] mode_next;
    logic [MODE_W-1:0] pins_meta_reg;
    logic [MODE_W-1:0] pins_sync_reg;
    logic [1:0] standby_sync_reg;
    logic [1:0] exit_sync_reg;
    logic exit_prev_reg;
    logic [NUM_STOPS-1:0] stop_bits;
    logic [NUM_STOPS-1:0] clk_en;

    wire ctrl_sel = (addr_i == STANDBY_SELECT_CTRL_TWO_ADDR);
    wire state_sel = (addr_i == STANDBY_STATE_ADDR);
    wire latch_sel = (addr_i == MODE_LATCH_ADDR);
    wire ctrl_wr = wr_i & ctrl_sel;
    wire exit_pulse = exit_sync_reg[1] & ~exit_prev_reg;
    // Relatch only when leaving software standby with the flag set
    wire relatch = exit_pulse & standby_sync_reg[1] & ctrl_reg[MODE_RELATCH_BIT];

    // Reserved bits are masked on write, so they always read back as zero
    assign ctrl_next = ctrl_wr ? (wdata_i & WRITE_MASK) : ctrl_reg;
    assign mode_next = relatch ? pins_sync_reg : mode_reg;
    assign rdata_next = ctrl_sel ? ctrl_reg :
                        state_sel ? {7'h00, standby_sync_reg[1]} :
                        latch_sel ? {2'h0, mode_reg} : READ_ZERO;
    assign stop_bits = ctrl_reg[STOP_LSB +: NUM_STOPS];

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl_reg <= CTRL_RESET;
            rdata_reg <= READ_ZERO;
        end else begin
            ctrl_reg <= ctrl_next;
            rdata_reg <= rd_i ? rdata_next : READ_ZERO;
        end
    end

    // Mode pins and standby status come from outside the clock domain
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pins_meta_reg <= MODE_RESET;
            pins_sync_reg <= MODE_RESET;
            standby_sync_reg <= 2'h0;
            exit_sync_reg <= 2'h0;
            exit_prev_reg <= 1'b0;
        end else begin
            pins_meta_reg <= mode_select_pins_i;
            pins_sync_reg <= pins_meta_reg;
            standby_sync_reg <= {standby_sync_reg[0], standby_active_i};
            exit_sync_reg <= {exit_sync_reg[0], standby_exit_i};
            exit_prev_reg <= exit_sync_reg[1];
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mode_reg <= MODE_RESET;
        end else begin
            mode_reg <= mode_next;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_STOPS; g++) begin : gen_gate
            msc_clock_gate u_gate (
                .clk_i(clk_i),
                .rstn_i(rstn_i),
                .stop_i(stop_bits[g]),
                .clk_en_o(clk_en[g])
            );
        end
    endgenerate

    assign fifo_serial_interface_clk_en_o = clk_en[SERIAL_STOP_BIT-STOP_LSB];
    assign adc_clk_en_o = clk_en[ADC_STOP_BIT-STOP_LSB];
    assign adc_init_o = ~clk_en[ADC_STOP_BIT-STOP_LSB];
    assign dac_clk_en_o = clk_en[DAC_STOP_BIT-STOP_LSB];
    assign dma_clk_en_o = clk_en[DMA_STOP_BIT-STOP_LSB];
    assign user_break_controller_clk_en_o = clk_en[BREAK_STOP_BIT-STOP_LSB];
    assign rdata_o = rdata_reg;
    assign mode_latched_o = mode_reg;
endmodule : msc_standby_ctrl

// file: src/msc_pkg.sv
// Package: offsets, field positions, reset values for the standby control block
package msc_pkg;
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 8;
    localparam logic [ADDR_W-1:0] STANDBY_SELECT_CTRL_TWO_ADDR = 4'h0;
    localparam logic [ADDR_W-1:0] STANDBY_STATE_ADDR = 4'h1;
    localparam logic [ADDR_W-1:0] MODE_LATCH_ADDR = 4'h2;
    localparam int unsigned MODE_RELATCH_BIT = 6;
    localparam int unsigned BREAK_STOP_BIT = 5;
    localparam int unsigned DMA_STOP_BIT = 4;
    localparam int unsigned DAC_STOP_BIT = 3;
    localparam int unsigned ADC_STOP_BIT = 2;
    localparam int unsigned SERIAL_STOP_BIT = 1;
    localparam int unsigned NUM_STOPS = 5;
    localparam int unsigned STOP_LSB = 1;
    localparam int unsigned MODE_W = 6;
    localparam logic [DATA_W-1:0] WRITE_MASK = 8'h7e;
    localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00;
    localparam logic [MODE_W-1:0] MODE_RESET = 6'h00;
    localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;
endpackage : msc_pkg

// file: src/msc_clock_gate.sv
// Glitch-free clock enable for one gated module
`timescale 1ns/10ps
module msc_clock_gate (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic stop_i,
    output logic clk_en_o
);
    // Outside reset the enable changes only on the rising edge, so a gate fed by it sees no partial pulse
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            clk_en_o <= 1'b1;
        end else begin
            clk_en_o <= ~stop_i;
        end
    end
endmodule : msc_clock_gate

// file: verification/msc_chk.sv
// Assertions for the standby control register block
`timescale 1ns/10ps
module msc_chk import msc_pkg::*; (
    input wire logic clk_i, rstn_i, wr_i, rd_i, standby_active_i, adc_init_o,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i, rdata_o,
    input wire logic [MODE_W-1:0] mode_latched_o,
    input wire logic user_break_controller_clk_en_o, dma_clk_en_o, dac_clk_en_o,
    input wire logic adc_clk_en_o, fifo_serial_interface_clk_en_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    wire w = wr_i && addr_i == STANDBY_SELECT_CTRL_TWO_ADDR;
    wire [4:0] en = {user_break_controller_clk_en_o, dma_clk_en_o, dac_clk_en_o, adc_clk_en_o,
        fifo_serial_interface_clk_en_o};
    property p_brk; w |-> ##2 en[4] != $past(wdata_i[5], 2); endproperty
    a_brk: assert property (p_brk) else $error("break enable");
    property p_dma; w |-> ##2 en[3] != $past(wdata_i[4], 2); endproperty
    a_dma: assert property (p_dma) else $error("dma enable");
    property p_dac; w |-> ##2 en[2] != $past(wdata_i[3], 2); endproperty
    a_dac: assert property (p_dac) else $error("dac enable");
    property p_adc; w |-> ##2 adc_init_o == $past(wdata_i[2], 2) && en[1] != adc_init_o; endproperty
    a_adc: assert property (p_adc) else $error("adc enable");
    property p_ser; w |-> ##2 en[0] != $past(wdata_i[1], 2); endproperty
    a_ser: assert property (p_ser) else $error("serial enable");
    property p_rsv; rd_i && addr_i == STANDBY_SELECT_CTRL_TWO_ADDR |=> !rdata_o[7] && !rdata_o[0]; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits");
    property p_idle; !rd_i |=> rdata_o == 8'h00; endproperty
    a_idle: assert property (p_idle) else $error("read data idle");
    // Enables only move after a write, so no glitch in between
    property p_hold; !wr_i [*3] |=> $stable(en); endproperty
    a_hold: assert property (p_hold) else $error("enable moved");
    property p_mode; !standby_active_i [*6] |=> $stable(mode_latched_o); endproperty
    a_mode: assert property (p_mode) else $error("mode changed");
    cover property (w ##2 !adc_clk_en_o);
    cover property (rd_i ##1 rdata_o != 8'h00);
    cover property (standby_active_i ##1 $changed(mode_latched_o));
endmodule : msc_chk
bind msc_standby_ctrl msc_chk u_chk (.*);

// file: verification/tb_top.sv
// Self-checking bench for the standby control register block
`timescale 1ns/10ps
module tb_top;
    import msc_pkg::*;
    logic clk_i = 0, rstn_i = 0, wr_i = 0, rd_i = 0, standby_active_i = 0, standby_exit_i = 0;
    logic [ADDR_W-1:0] addr_i = '0;
    logic [DATA_W-1:0] wdata_i = '0, rdata_o;
    logic [MODE_W-1:0] mode_select_pins_i = '0, mode_latched_o;
    logic user_break_controller_clk_en_o, dma_clk_en_o, dac_clk_en_o, adc_clk_en_o;
    logic fifo_serial_interface_clk_en_o, adc_init_o;
    wire [4:0] en = {user_break_controller_clk_en_o, dma_clk_en_o, dac_clk_en_o, adc_clk_en_o,
        fifo_serial_interface_clk_en_o};
    int errors = 0, n_tests = 0, cyc = 0;
    msc_standby_ctrl dut (.*);
    initial forever #50 clk_i = ~clk_i;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        {wr_i, addr_i, wdata_i} <= {1'b1, a, d};
        @(posedge clk_i);
        wr_i <= 0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk_i);
        {rd_i, addr_i} <= {1'b1, a};
        @(posedge clk_i);
        rd_i <= 0;
        #1 chk(rdata_o, e);
    endtask : rd
    // Exit edge must land while standby is still seen, hence the overlap
    task automatic relatch;
        standby_active_i <= 1;
        repeat (3) @(posedge clk_i);
        standby_exit_i <= 1;
        repeat (6) @(posedge clk_i);
        {standby_active_i, standby_exit_i} <= 2'h0;
        repeat (8) @(posedge clk_i);
    endtask : relatch
    task automatic report_and_stop;
        $display("Checks %0d, errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : report_and_stop
    always @(posedge clk_i) begin
        cyc++;
        if (cyc > 1000) begin
            errors++;
            report_and_stop();
        end
    end
    initial begin
        repeat (20) @(posedge clk_i);
        rstn_i <= 1;
        rd(STANDBY_SELECT_CTRL_TWO_ADDR, 8'h00);
        chk(en, 8'h1f);
        wr(STANDBY_SELECT_CTRL_TWO_ADDR, 8'hff);
        rd(STANDBY_SELECT_CTRL_TWO_ADDR, 8'h7e);
        chk({adc_init_o, en}, 8'h20);
        rd(4'hf, 8'h00);
        for (int i = 1; i < 6; i++) begin
            wr(STANDBY_SELECT_CTRL_TWO_ADDR, 8'h01 << i);
            repeat (2) @(posedge clk_i);
            // Compare as zero-extended 5-bit vectors so upper bits cannot spoil it
            #1 chk(en, 8'h1f ^ (8'h01 << (i - 1)));
        end
        mode_select_pins_i <= 6'h2a;
        wr(STANDBY_SELECT_CTRL_TWO_ADDR, 8'h40);
        relatch();
        chk(mode_latched_o, 8'h2a);
        mode_select_pins_i <= 6'h15;
        wr(STANDBY_SELECT_CTRL_TWO_ADDR, 8'h00);
        relatch();
        chk(mode_latched_o, 8'h2a);
        report_and_stop();
    end
endmodule : tb_top
